/* File: src/dscg_pkg.sv */
package dscg_pkg;

    // ------------------------------------------------------------------
    // register map (byte addresses, address bits 11..2 decoded)
    // ------------------------------------------------------------------
    localparam logic [11:0] DSCG_OFF_RUN_CFG = 12'h060;
    localparam logic [11:0] DSCG_OFF_RUN_BANK = 12'h104;
    localparam logic [11:0] DSCG_OFF_SLEEP_BANK = 12'h114;
    localparam logic [11:0] DSCG_OFF_DEEP_BANK = 12'h124;
    localparam logic [11:0] DSCG_OFF_FAULT_STAT = 12'h200;
    localparam logic [11:0] DSCG_OFF_FAULT_MASK = 12'h204;

    // ------------------------------------------------------------------
    // field layout and reset values
    // ------------------------------------------------------------------
    localparam int DSCG_UNITS = 8;
    // unit index -> gating bit: async serial, sync serial, quad decoder,
    // general-purpose counters 0..3, comparator
    localparam int DSCG_UNIT_BIT [0:7] = '{0, 4, 8, 16, 17, 18, 19, 24};
    localparam logic [31:0] DSCG_GATE_WR_MASK = 32'h010F0111;
    localparam logic [31:0] DSCG_GATE_RESET = 32'h00000000;
    localparam int DSCG_CFG_AUTO_BIT = 27;
    localparam logic [31:0] DSCG_CFG_WR_MASK = 32'h08000000;
    localparam logic [31:0] DSCG_CFG_RESET = 32'h00000000;
    localparam logic [31:0] DSCG_STAT_RESET = 32'h00000000;
    localparam logic [31:0] DSCG_MASK_RESET = 32'h00000000;
    localparam logic [1:0] DSCG_HRESP_OKAY = 2'h0;

    // ------------------------------------------------------------------
    // power states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        DSCG_RUN = 3'h1,
        DSCG_SLEEP = 3'h2,
        DSCG_DEEP = 3'h4
    } dscg_pstate_t;

endpackage

/* File: src/dscg_clk_gate.sv */
`timescale 1ns/1ps
module dscg_clk_gate (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_en,
    output logic o_gclk
);
    import dscg_pkg::*;

    // ------------------------------------------------------------------
    // glitch-free gate
    // ------------------------------------------------------------------
    logic en_low;

    // enable moves on falling edge
    // enable only changes while the clock is low, so no runt pulse
    always_ff @(negedge i_clk) begin
        if (i_srst) begin
            en_low <= 1'b0;
        end else begin
            en_low <= i_en;
        end
    end

    assign o_gclk = i_clk & en_low;

endmodule // dscg_clk_gate

/* File: src/dscg_top.sv */
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/1ps
// Notes on behaviour
// - each implemented gating bit is the clock enable of one unit
// - bit set: unit gets its clock and runs
// - bit clear: unit clock stopped and unit held disabled
// - access to an unclocked unit answers with a bus fault
// - all gating bits reset to zero, every unit unclocked
// - run, sleep and deep-sleep banks; the current state's bank applies
// - sleep and deep-sleep banks honoured only with auto gating set
// - bit 24 gates the analog comparator, read-write
// - bits 19..16 gate timers 3..0, read-write
// - bit 8 gates the quadrature decoder, read-write
// - bit 4 gates the synchronous serial port, read-write
// - bit 0 gates the asynchronous serial port, read-write
// - unused bits read zero; software preserves them on updates
module dscg_top #(
    parameter int UNITS = dscg_pkg::DSCG_UNITS
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic [1:0] o_hresp,
    input wire logic i_sleep_req,
    input wire logic i_deep_sleep_req,
    input wire logic [UNITS-1:0] i_unit_access,
    output logic [UNITS-1:0] o_unit_fault,
    output logic [UNITS-1:0] o_unit_enable,
    output logic [UNITS-1:0] o_unit_clk,
    output logic o_irq
);
    import dscg_pkg::*;

    // ------------------------------------------------------------------
    // bus address phase
    // ------------------------------------------------------------------
    wire acc = i_hsel & i_htrans[1] & i_hready;
    wire acc_rd = acc & ~i_hwrite;
    wire [9:0] a_word = i_haddr[11:2];
    logic dp_wr;
    logic [9:0] dp_word;

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            dp_wr <= 1'b0;
            dp_word <= 10'h000;
        end else begin
            dp_wr <= acc & i_hwrite;
            dp_word <= a_word;
        end
    end

    // ------------------------------------------------------------------
    // register state
    // ------------------------------------------------------------------
    logic [31:0] run_bank;
    logic [31:0] sleep_bank;
    logic [31:0] deep_bank;
    logic [31:0] run_cfg;
    logic [31:0] fault_stat;
    logic [31:0] fault_mask;
    dscg_pstate_t pstate;
    dscg_pstate_t next_pstate;
    logic [31:0] fault_evt;

    wire wr_run = dp_wr & (dp_word == DSCG_OFF_RUN_BANK[11:2]);
    wire wr_sleep = dp_wr & (dp_word == DSCG_OFF_SLEEP_BANK[11:2]);
    wire wr_deep = dp_wr & (dp_word == DSCG_OFF_DEEP_BANK[11:2]);
    wire wr_cfg = dp_wr & (dp_word == DSCG_OFF_RUN_CFG[11:2]);
    wire wr_mask = dp_wr & (dp_word == DSCG_OFF_FAULT_MASK[11:2]);
    wire rd_stat = acc_rd & (a_word == DSCG_OFF_FAULT_STAT[11:2]);

    wire [31:0] wdata_gate = i_hwdata & DSCG_GATE_WR_MASK;
    wire [31:0] next_run = wr_run ? wdata_gate : run_bank;
    wire [31:0] next_sleep = wr_sleep ? wdata_gate : sleep_bank;
    wire [31:0] next_deep = wr_deep ? wdata_gate : deep_bank;
    wire [31:0] next_cfg = wr_cfg ? (i_hwdata & DSCG_CFG_WR_MASK) : run_cfg;
    wire [31:0] next_mask = wr_mask ? wdata_gate : fault_mask;
    // a fault arriving with the clearing read survives it
    wire [31:0] next_stat = (fault_stat & ~{32{rd_stat}}) | fault_evt;

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            run_bank <= DSCG_GATE_RESET;
            sleep_bank <= DSCG_GATE_RESET;
            deep_bank <= DSCG_GATE_RESET;
            run_cfg <= DSCG_CFG_RESET;
            fault_stat <= DSCG_STAT_RESET;
            fault_mask <= DSCG_MASK_RESET;
        end else begin
            run_bank <= next_run;
            sleep_bank <= next_sleep;
            deep_bank <= next_deep;
            run_cfg <= next_cfg;
            fault_stat <= next_stat;
            fault_mask <= next_mask;
        end
    end

    // ------------------------------------------------------------------
    // read mux and bus answer
    // ------------------------------------------------------------------
    // read from next_ values so a write followed at once by a read of the
    // same register returns the new contents with zero wait states
    logic [31:0] rd_val;
    always_comb begin
        case (a_word)
            DSCG_OFF_RUN_BANK[11:2]: rd_val = next_run;
            DSCG_OFF_SLEEP_BANK[11:2]: rd_val = next_sleep;
            DSCG_OFF_DEEP_BANK[11:2]: rd_val = next_deep;
            DSCG_OFF_RUN_CFG[11:2]: rd_val = next_cfg;
            DSCG_OFF_FAULT_STAT[11:2]: rd_val = fault_stat | fault_evt;
            DSCG_OFF_FAULT_MASK[11:2]: rd_val = next_mask;
            default: rd_val = 32'h00000000;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_hrdata <= 32'h00000000;
            o_hreadyout <= 1'b1;
            o_hresp <= DSCG_HRESP_OKAY;
        end else begin
            o_hrdata <= acc_rd ? rd_val : 32'h00000000;
            o_hreadyout <= 1'b1;
            o_hresp <= DSCG_HRESP_OKAY;
        end
    end

    // ------------------------------------------------------------------
    // power state and bank selection
    // ------------------------------------------------------------------
    wire auto_gate = run_cfg[DSCG_CFG_AUTO_BIT];

    always_comb begin
        if (i_deep_sleep_req) begin
            next_pstate = DSCG_DEEP;
        end else if (i_sleep_req) begin
            next_pstate = DSCG_SLEEP;
        end else begin
            next_pstate = DSCG_RUN;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            pstate <= DSCG_RUN;
        end else begin
            pstate <= next_pstate;
        end
    end

    // bank by state
    // without auto gating the run bank applies in every state
    logic [31:0] eff_bank;
    always_comb begin
        case (pstate)
            DSCG_RUN: eff_bank = run_bank;
            DSCG_SLEEP: eff_bank = auto_gate ? sleep_bank : run_bank;
            DSCG_DEEP: eff_bank = auto_gate ? deep_bank : run_bank;
            default: eff_bank = run_bank;
        endcase
    end

    // ------------------------------------------------------------------
    // per-unit enables, clocks and faults
    // ------------------------------------------------------------------
    logic [UNITS-1:0] eff_units;
    logic [UNITS-1:0] fault_now;
    logic [UNITS-1:0] run_units;
    logic [UNITS-1:0] deep_units;

    for (genvar gi = 0; gi < UNITS; gi++) begin : g_unit
        assign eff_units[gi] = eff_bank[DSCG_UNIT_BIT[gi]];
        assign run_units[gi] = run_bank[DSCG_UNIT_BIT[gi]];
        assign deep_units[gi] = deep_bank[DSCG_UNIT_BIT[gi]];
        assign fault_now[gi] = i_unit_access[gi] & ~o_unit_enable[gi];
        assign fault_evt[DSCG_UNIT_BIT[gi]] = fault_now[gi];

        dscg_clk_gate u_gate (
            .i_clk(i_clk),
            .i_srst(i_srst),
            .i_en(o_unit_enable[gi]),
            .o_gclk(o_unit_clk[gi])
        );
    end

    // unmapped event bits stay zero
    for (genvar gb = 0; gb < 32; gb++) begin : g_evt_zero
        if (!DSCG_GATE_WR_MASK[gb]) begin : g_z
            assign fault_evt[gb] = 1'b0;
        end
    end

    // enable held low keeps unit disabled
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_unit_enable <= '0;
            o_unit_fault <= '0;
            o_irq <= 1'b0;
        end else begin
            o_unit_enable <= eff_units;
            o_unit_fault <= fault_now;
            o_irq <= |(next_stat & fault_mask);
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    sequence s_deep_wr_addr;
        acc & i_hwrite & (a_word == DSCG_OFF_DEEP_BANK[11:2]);
    endsequence

    sequence s_deep_wr_data;
        s_deep_wr_addr ##1 1'b1;
    endsequence

    property p_reset_zero;
        @(posedge i_clk) i_srst |=> (deep_bank == DSCG_GATE_RESET)
            && (o_unit_enable == '0);
    endproperty
    a_reset_zero: assert property (p_reset_zero)
        else $error("bank or enable not zero after reset");

    property p_run_bank_rules;
        @(posedge i_clk) disable iff (i_srst)
            (!auto_gate) |=> (o_unit_enable == $past(run_units));
    endproperty
    a_run_bank_rules: assert property (p_run_bank_rules)
        else $error("run bank not applied without auto gating");

    property p_deep_bank_used;
        @(posedge i_clk) disable iff (i_srst)
            (auto_gate && pstate == DSCG_DEEP)
            |=> (o_unit_enable == $past(deep_units));
    endproperty
    a_deep_bank_used: assert property (p_deep_bank_used)
        else $error("deep bank not applied in deep sleep");

    property p_fault_gated;
        @(posedge i_clk) disable iff (i_srst)
            ##1 (o_unit_fault == $past(i_unit_access & ~o_unit_enable));
    endproperty
    a_fault_gated: assert property (p_fault_gated)
        else $error("fault answer does not match gated access");

    property p_reserved_zero;
        @(posedge i_clk) disable iff (i_srst)
            ((deep_bank | run_bank | sleep_bank) & ~DSCG_GATE_WR_MASK)
            == 32'h00000000;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved gating bit became set");

    property p_wr_comp;
        @(posedge i_clk) disable iff (i_srst)
            s_deep_wr_data |=> (deep_bank[24] == $past(i_hwdata[24]));
    endproperty
    a_wr_comp: assert property (p_wr_comp)
        else $error("comparator bit not written");

    property p_wr_timers;
        @(posedge i_clk) disable iff (i_srst)
            s_deep_wr_data |=> (deep_bank[19:16] == $past(i_hwdata[19:16]));
    endproperty
    a_wr_timers: assert property (p_wr_timers)
        else $error("timer bits not written");

    property p_wr_qdec;
        @(posedge i_clk) disable iff (i_srst)
            s_deep_wr_data |=> (deep_bank[8] == $past(i_hwdata[8]));
    endproperty
    a_wr_qdec: assert property (p_wr_qdec)
        else $error("quadrature decoder bit not written");

    property p_wr_sync;
        @(posedge i_clk) disable iff (i_srst)
            s_deep_wr_data |=> (deep_bank[4] == $past(i_hwdata[4]));
    endproperty
    a_wr_sync: assert property (p_wr_sync)
        else $error("sync serial bit not written");

    property p_wr_async;
        @(posedge i_clk) disable iff (i_srst)
            s_deep_wr_data |=> (deep_bank[0] == $past(i_hwdata[0]));
    endproperty
    a_wr_async: assert property (p_wr_async)
        else $error("async serial bit not written");

    property p_enable_follows;
        @(posedge i_clk) disable iff (i_srst)
            $rose(eff_units[0]) |=> o_unit_enable[0] ##1 o_unit_enable[0]
                || !$past(eff_units[0]);
    endproperty
    a_enable_follows: assert property (p_enable_follows)
        else $error("unit enable did not follow its gating bit");

    property p_irq_level;
        @(posedge i_clk) disable iff (i_srst)
            ##1 (o_irq == |($past(next_stat) & $past(fault_mask)));
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("interrupt level wrong");

endmodule // dscg_top

/* File: sim/dscg_tb.sv */
`timescale 1ns/1ps
module testbench;
    import dscg_pkg::*;

    // ------------------------------------------------------------------
    // bench signals
    // ------------------------------------------------------------------
    logic clk;
    logic srst;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic hreadyout;
    logic [1:0] hresp;
    logic sleep_req;
    logic deep_req;
    logic [7:0] unit_access;
    logic [7:0] unit_fault;
    logic [7:0] unit_enable;
    logic [7:0] unit_clk;
    logic irq;
    int fail_count;
    int num_checks;

    dscg_top #(.UNITS(DSCG_UNITS)) dut (
        .i_clk(clk), .i_srst(srst), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
        .i_hwdata(hwdata), .i_hready(hreadyout), .o_hrdata(hrdata),
        .o_hreadyout(hreadyout), .o_hresp(hresp), .i_sleep_req(sleep_req),
        .i_deep_sleep_req(deep_req), .i_unit_access(unit_access),
        .o_unit_fault(unit_fault), .o_unit_enable(unit_enable),
        .o_unit_clk(unit_clk), .o_irq(irq)
    );

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ------------------------------------------------------------------
    // shared helpers
    // ------------------------------------------------------------------
    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d failures %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // expected unit enables from a bank value
    function automatic logic [7:0] units_of(input logic [31:0] b);
        logic [7:0] u;
        for (int k = 0; k < 8; k++) u[k] = b[DSCG_UNIT_BIT[k]];
        return u;
    endfunction

    function automatic logic [31:0] bits_of(input logic [7:0] u);
        logic [31:0] b;
        b = 32'h00000000;
        for (int k = 0; k < 8; k++) b[DSCG_UNIT_BIT[k]] = u[k];
        return b;
    endfunction

    // sampled at the low phase so values equal those at the next edge
    task automatic wait_rdy(output logic [31:0] d);
        logic r;
        r = 1'b0;
        while (r !== 1'b1) begin
            @(negedge clk);
            r = hreadyout;
            d = hrdata;
            @(posedge clk);
        end
    endtask

    // callers enter right after a rising edge
    task automatic bus_xfer(input logic [11:0] a, input logic wr,
                            input logic [31:0] wd, output logic [31:0] rd);
        logic [31:0] tmp;
        hsel <= 1'b1;
        haddr <= {20'h00000, a};
        htrans <= 2'h2;
        hwrite <= wr;
        wait_rdy(tmp);
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy(rd);
        check("hresp", {30'h0, hresp}, {30'h0, DSCG_HRESP_OKAY});
    endtask

    task automatic bus_wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        bus_xfer(a, 1'b1, d, dummy);
    endtask

    task automatic rd_check(input string nm, input logic [11:0] a,
                            input logic [31:0] exp);
        logic [31:0] d;
        bus_xfer(a, 1'b0, 32'h00000000, d);
        check(nm, d, exp);
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset_values();
        rd_check("deep bank", DSCG_OFF_DEEP_BANK, DSCG_GATE_RESET);
        rd_check("run bank", DSCG_OFF_RUN_BANK, DSCG_GATE_RESET);
        rd_check("sleep bank", DSCG_OFF_SLEEP_BANK, DSCG_GATE_RESET);
        rd_check("run cfg", DSCG_OFF_RUN_CFG, DSCG_CFG_RESET);
        rd_check("fault mask", DSCG_OFF_FAULT_MASK, DSCG_MASK_RESET);
        check("enable", {24'h0, unit_enable}, 32'h00000000);
        check("irq", {31'h0, irq}, 32'h00000000);
    endtask

    task automatic t_bit_map();
        bus_wr(DSCG_OFF_DEEP_BANK, 32'hFFFFFFFF);
        rd_check("all ones", DSCG_OFF_DEEP_BANK, 32'h010F0111);
        for (int k = 0; k < 8; k++) begin
            bus_wr(DSCG_OFF_DEEP_BANK, 32'h00000001 << DSCG_UNIT_BIT[k]);
            rd_check("one bit", DSCG_OFF_DEEP_BANK,
                     32'h00000001 << DSCG_UNIT_BIT[k]);
        end
        bus_wr(DSCG_OFF_DEEP_BANK, 32'hFEF0FEEE);
        rd_check("reserved", DSCG_OFF_DEEP_BANK, 32'h00000000);
        bus_wr(12'h300, 32'hFFFFFFFF);
        rd_check("unmapped", 12'h300, 32'h00000000);
    endtask

    // unit clock high in the high phase only when enabled
    task automatic gate_state(input logic sl, input logic dp,
                              input logic [31:0] bank);
        logic [31:0] u;
        u = {24'h0, units_of(bank)};
        sleep_req <= sl;
        deep_req <= dp;
        repeat (4) @(posedge clk);
        #2;
        check("enable", {24'h0, unit_enable}, u);
        check("clk high", {24'h0, unit_clk}, u);
        @(negedge clk);
        #2;
        check("clk low", {24'h0, unit_clk}, 32'h00000000);
        @(posedge clk);
    endtask

    task automatic t_banks();
        bus_wr(DSCG_OFF_RUN_BANK, 32'h00000001);
        bus_wr(DSCG_OFF_SLEEP_BANK, 32'h00000010);
        bus_wr(DSCG_OFF_DEEP_BANK, 32'h010F0000);
        gate_state(1'b0, 1'b1, 32'h00000001);
        bus_wr(DSCG_OFF_RUN_CFG, 32'h08000000);
        gate_state(1'b0, 1'b1, 32'h010F0000);
        gate_state(1'b1, 1'b0, 32'h00000010);
        gate_state(1'b1, 1'b1, 32'h010F0000);
        gate_state(1'b0, 1'b0, 32'h00000001);
    endtask

    task automatic pulse(input logic [7:0] v, input logic [7:0] exp_f,
                         input logic exp_irq);
        unit_access <= v;
        @(posedge clk);
        unit_access <= 8'h00;
        @(negedge clk);
        check("fault", {24'h0, unit_fault}, {24'h0, exp_f});
        @(posedge clk);
        @(negedge clk);
        check("irq", {31'h0, irq}, {31'h0, exp_irq});
        @(posedge clk);
    endtask

    // run bank applies: only unit 0 is clocked
    task automatic t_faults();
        pulse(8'hFF, 8'hFE, 1'b0);
        rd_check("status", DSCG_OFF_FAULT_STAT, bits_of(8'hFE));
        rd_check("status clr", DSCG_OFF_FAULT_STAT, DSCG_STAT_RESET);
        bus_wr(DSCG_OFF_FAULT_MASK, 32'h010F0111);
        pulse(8'h01, 8'h00, 1'b0);
        pulse(8'h80, 8'h80, 1'b1);
        rd_check("status", DSCG_OFF_FAULT_STAT, 32'h01000000);
        @(negedge clk);
        check("irq clr", {31'h0, irq}, 32'h00000000);
        @(posedge clk);
    endtask

    task automatic t_mid_reset();
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        rd_check("deep again", DSCG_OFF_DEEP_BANK, 32'h00000000);
        check("enable", {24'h0, unit_enable}, 32'h00000000);
    endtask

    // ------------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        fail_count = 0;
        num_checks = 0;
        srst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
        sleep_req = 1'b0;
        deep_req = 1'b0;
        unit_access = 8'h00;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        t_reset_values();
        t_bit_map();
        t_banks();
        t_faults();
        t_mid_reset();
        give_verdict();
    end

    // the whole run needs well under a thousand cycles
    initial begin
        #80000;
        fail_count++;
        give_verdict();
    end

endmodule // testbench
